//--- rtl/tweep_slave.sv
// Two-wire serial EEPROM slave: protocol engine, page buffer and write timer
`timescale 1ns/10ps
// How it works
// [RQ1] Input bits are taken at scl rising edges, output bits change at falling edges.
// [RQ2] Select pins read as low when unconnected; bench drives them with a random value after reset.
// [RQ3] Write protect high blocks all programming; reads are unaffected.
// [RQ4] Array is 512 pages of 64 bytes, 15-bit byte address.
// [RQ5] Controller moves sda only while scl is low.
// [RQ6] Sda falling while scl high is a start; every command opens with one.
// [RQ7] Sda rising while scl high is a stop; commands close with one.
// [RQ8] Stop after read returns to standby at once; after write, once programmed.
// [RQ9] Bytes are eight bits; device pulls sda low on the ninth clock.
// [RQ10] Standby is entered straight out of reset.
// [RQ11] Device address byte follows each start; top nibble must be 1010.
// [RQ12] Address bits five to seven must match the select pins, else standby.
// [RQ13] Eighth address bit set selects read, clear selects write.
// [RQ14] Byte write: two address bytes then one data byte, each acknowledged.
// [RQ15] Stop after a write starts timed programming; inputs ignored meanwhile.
// [RQ16] Programming completes within 5 ms.
// [RQ17] Page write takes up to 63 more bytes, each acknowledged, then stop.
// [RQ18] Only the six low address bits advance per data byte; page wraps.
// [RQ19] No address acknowledge while programming; normal once back in standby.
// [RQ20] Partial pages program only the bytes actually received.
// [RQ21] Address counter keeps last accessed address plus one for current reads.
// [RQ22] Read shifts one byte per increment; master ack asks for more.
// [RQ23] Sequential read wraps from the top address back to zero.
// [RQ24] High address byte comes first, msb first; its top bit is ignored.
// [RQ25] A start inside any phase aborts and restarts address reception; the code ignores starts during timed programming.
module tweep_slave #(
    parameter logic [16:0] PROG_CYCLES = tweep_pkg::PROG_CYCLES
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Two-wire link, sda is open drain
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Straps and protection
    input wire logic selectBitHigh,
    input wire logic selectBitMid,
    input wire logic selectBitLow,
    input wire logic writeProtect,
    // Status
    output logic standby
);

    // Synchronised pins
    logic [tweep_pkg::SYNC_W-1:0] pinsAsync;
    logic [tweep_pkg::SYNC_W-1:0] pinsSync;
    logic sclS;
    logic sdaS;
    logic wpS;
    logic [2:0] selS;

    // Edge detection
    logic sclPrev_reg;
    logic sdaPrev_reg;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    // Protocol state
    tweep_pkg::tweep_state_t state_reg;
    tweep_pkg::tweep_state_t state_next;
    logic [3:0] bitCnt_reg;
    logic [3:0] bitCnt_next;
    logic [1:0] byteIdx_reg;
    logic [1:0] byteIdx_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [14:0] addr_reg;
    logic [14:0] addr_next;
    logic readMode_reg;
    logic readMode_next;
    logic masterAck_reg;
    logic masterAck_next;
    logic sdaOe_reg;
    logic sdaOe_next;
    logic [16:0] progCnt_reg;
    logic [16:0] progCnt_next;

    // Decode
    logic byteDone;
    logic devMatch;
    logic progDone;
    logic startProg;
    logic anyValid;
    logic bufWe;
    logic clrBuf;

    // Page buffer and array ports
    logic [7:0] bufData_reg [0:tweep_pkg::PAGE_BYTES-1];
    logic [tweep_pkg::PAGE_BYTES-1:0] bufValid_reg;
    logic [5:0] bufIdx;
    logic [5:0] commitIdx;
    logic commitWin;
    logic memWe;
    logic [14:0] memWrAddr;
    logic [7:0] memWrData;
    logic [7:0] rdData;

    assign pinsAsync[tweep_pkg::LANE_SCL] = scl;
    assign pinsAsync[tweep_pkg::LANE_SDA] = sdaIn;
    assign pinsAsync[tweep_pkg::LANE_WP] = writeProtect;
    assign pinsAsync[tweep_pkg::LANE_SEL_LOW] = selectBitLow;
    assign pinsAsync[tweep_pkg::LANE_SEL_MID] = selectBitMid;
    assign pinsAsync[tweep_pkg::LANE_SEL_HIGH] = selectBitHigh;

    tweep_sync #(
        .WIDTH(tweep_pkg::SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async(pinsAsync),
        .synced(pinsSync)
    );

    assign sclS = pinsSync[tweep_pkg::LANE_SCL];
    assign sdaS = pinsSync[tweep_pkg::LANE_SDA];
    assign wpS = pinsSync[tweep_pkg::LANE_WP];
    assign selS = {pinsSync[tweep_pkg::LANE_SEL_HIGH], pinsSync[tweep_pkg::LANE_SEL_MID],
                   pinsSync[tweep_pkg::LANE_SEL_LOW]}; // RQ2

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end
        else
        begin
            sclPrev_reg <= sclS;
            sdaPrev_reg <= sdaS;
        end
    end

    // Scl and sda share the same latency, so a data change inside scl low
    // never looks like a start or stop
    assign sclRise = sclS & ~sclPrev_reg; // RQ1
    assign sclFall = ~sclS & sclPrev_reg; // RQ1
    assign startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS; // RQ6
    assign stopCond = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS; // RQ7

    assign byteDone = (bitCnt_reg == tweep_pkg::BIT_CNT_FULL); // RQ9
    assign devMatch = (shift_reg[tweep_pkg::DEV_TYPE_MSB:tweep_pkg::DEV_TYPE_LSB]
                       == tweep_pkg::DEV_TYPE_CODE) // RQ11
                      && (shift_reg[tweep_pkg::SEL_MSB:tweep_pkg::SEL_LSB] == selS); // RQ12
    assign anyValid = |bufValid_reg;
    // Address-only writes just load the counter and need no timed cycle
    assign startProg = ~readMode_reg && (byteIdx_reg == tweep_pkg::BIDX_DATA)
                       && anyValid && ~wpS; // RQ3 RQ15
    assign progDone = (progCnt_reg == PROG_CYCLES - 17'h00001); // RQ16

    // Buffered bytes are copied one per cycle at the start of the timed cycle
    assign commitIdx = progCnt_reg[5:0];
    assign commitWin = (progCnt_reg < tweep_pkg::COMMIT_WINDOW);
    assign memWe = (state_reg == tweep_pkg::ST_PROG) && commitWin
                   && bufValid_reg[commitIdx] && ~wpS; // RQ3 RQ20
    assign memWrAddr = {addr_reg[14:6], commitIdx}; // RQ4
    assign memWrData = bufData_reg[commitIdx];
    assign bufIdx = addr_reg[5:0];

    always_comb
    begin
        state_next = state_reg;
        bitCnt_next = bitCnt_reg;
        byteIdx_next = byteIdx_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        readMode_next = readMode_reg;
        masterAck_next = masterAck_reg;
        sdaOe_next = sdaOe_reg;
        progCnt_next = progCnt_reg;
        bufWe = 1'b0;
        clrBuf = 1'b0;
        if (state_reg == tweep_pkg::ST_PROG)
        begin
            // Deaf to the link: no address is acknowledged until done
            progCnt_next = progCnt_reg + 17'h00001; // RQ15 RQ19
            if (progDone)
            begin
                state_next = tweep_pkg::ST_IDLE; // RQ8
                progCnt_next = tweep_pkg::PROG_CNT_ZERO;
                clrBuf = 1'b1;
            end
        end
        else if (startCond)
        begin
            state_next = tweep_pkg::ST_RX; // RQ25
            bitCnt_next = tweep_pkg::BIT_CNT_ZERO;
            byteIdx_next = tweep_pkg::BIDX_DEV;
            sdaOe_next = 1'b0;
            clrBuf = 1'b1;
        end
        else if (stopCond)
        begin
            sdaOe_next = 1'b0;
            if (startProg)
            begin
                state_next = tweep_pkg::ST_PROG; // RQ8 RQ15
            end
            else
            begin
                state_next = tweep_pkg::ST_IDLE; // RQ8
                clrBuf = 1'b1;
            end
        end
        else
        begin
            case (state_reg)
                tweep_pkg::ST_RX:
                begin
                    if (sclRise && !byteDone)
                    begin
                        shift_next = {shift_reg[6:0], sdaS}; // RQ1 RQ24
                        bitCnt_next = bitCnt_reg + tweep_pkg::BIT_CNT_ONE;
                    end
                    else if (sclFall && byteDone)
                    begin
                        bitCnt_next = tweep_pkg::BIT_CNT_ZERO;
                        state_next = tweep_pkg::ST_ACK;
                        sdaOe_next = 1'b1; // RQ9 RQ14 RQ17
                        if (byteIdx_reg != tweep_pkg::BIDX_DATA)
                        begin
                            byteIdx_next = byteIdx_reg + 2'h1;
                        end
                        case (byteIdx_reg)
                            tweep_pkg::BIDX_DEV:
                            begin
                                if (!devMatch)
                                begin
                                    state_next = tweep_pkg::ST_IDLE; // RQ12
                                    sdaOe_next = 1'b0;
                                end
                                readMode_next = shift_reg[tweep_pkg::RW_BIT]; // RQ13
                            end
                            tweep_pkg::BIDX_ADDR_HI:
                            begin
                                // Top bit of the high byte is dropped
                                addr_next = {shift_reg[6:0], addr_reg[7:0]}; // RQ24
                            end
                            tweep_pkg::BIDX_ADDR_LO:
                            begin
                                addr_next = {addr_reg[14:8], shift_reg}; // RQ14
                            end
                            default:
                            begin
                                bufWe = 1'b1; // RQ20
                                addr_next = {addr_reg[14:6], addr_reg[5:0] + 6'h01}; // RQ18
                            end
                        endcase
                    end
                end
                tweep_pkg::ST_ACK:
                begin
                    if (sclFall)
                    begin
                        if (readMode_reg)
                        begin
                            state_next = tweep_pkg::ST_TX; // RQ21 RQ22
                            shift_next = rdData;
                            sdaOe_next = ~rdData[7]; // RQ1
                            bitCnt_next = tweep_pkg::BIT_CNT_ONE;
                        end
                        else
                        begin
                            state_next = tweep_pkg::ST_RX;
                            sdaOe_next = 1'b0;
                        end
                    end
                end
                tweep_pkg::ST_TX:
                begin
                    if (sclFall)
                    begin
                        if (byteDone)
                        begin
                            state_next = tweep_pkg::ST_MACK;
                            sdaOe_next = 1'b0;
                            addr_next = addr_reg + 15'h0001; // RQ21 RQ23
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sdaOe_next = ~shift_reg[6]; // RQ1
                            bitCnt_next = bitCnt_reg + tweep_pkg::BIT_CNT_ONE;
                        end
                    end
                end
                tweep_pkg::ST_MACK:
                begin
                    if (sclRise)
                    begin
                        masterAck_next = ~sdaS; // RQ22
                    end
                    else if (sclFall)
                    begin
                        if (masterAck_reg)
                        begin
                            state_next = tweep_pkg::ST_TX; // RQ22
                            shift_next = rdData;
                            sdaOe_next = ~rdData[7];
                            bitCnt_next = tweep_pkg::BIT_CNT_ONE;
                        end
                        else
                        begin
                            // Bus left free; the stop that follows is harmless
                            state_next = tweep_pkg::ST_IDLE; // RQ22
                        end
                    end
                end
                default:
                begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg <= tweep_pkg::ST_IDLE; // RQ10
            progCnt_reg <= tweep_pkg::PROG_CNT_ZERO;
        end
        else
        begin
            state_reg <= state_next;
            progCnt_reg <= progCnt_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bitCnt_reg <= tweep_pkg::BIT_CNT_ZERO;
            byteIdx_reg <= tweep_pkg::BIDX_DEV;
            shift_reg <= 8'h00;
            readMode_reg <= 1'b0;
            masterAck_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
        end
        else
        begin
            bitCnt_reg <= bitCnt_next;
            byteIdx_reg <= byteIdx_next;
            shift_reg <= shift_next;
            readMode_reg <= readMode_next;
            masterAck_reg <= masterAck_next;
            sdaOe_reg <= sdaOe_next;
        end
    end

    // Counter survives every command; only reset clears it
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            addr_reg <= tweep_pkg::ADDR_RESET;
        end
        else
        begin
            addr_reg <= addr_next; // RQ21
        end
    end

    // Page buffer: one entry per byte of the page, valid marks what arrived
    genvar gi;
    generate
        for (gi = 0; gi < tweep_pkg::PAGE_BYTES; gi++)
        begin : g_page
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    bufData_reg[gi] <= 8'h00;
                    bufValid_reg[gi] <= 1'b0;
                end
                else if (bufWe && (bufIdx == 6'(gi)))
                begin
                    bufData_reg[gi] <= shift_reg; // RQ18
                    bufValid_reg[gi] <= 1'b1; // RQ20
                end
                else if (clrBuf)
                begin
                    bufValid_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    tweep_mem u_mem (
        .mclk(mclk),
        .rst(rst),
        .we(memWe),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddr(addr_reg),
        .rdData(rdData)
    );

    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_reg;
    assign standby = (state_reg == tweep_pkg::ST_IDLE);

endmodule // tweep_slave

//--- rtl/tweep_pkg.sv
// Shared constants and types for the two-wire EEPROM slave
package tweep_pkg;

    // Array geometry
    localparam int BYTE_BITS = 8;
    localparam int ADDR_W = 15;
    localparam int PAGE_BITS = 6;
    localparam int PAGE_BYTES = 64;
    localparam int NUM_PAGES = 512;
    localparam int NUM_BYTES = NUM_PAGES * PAGE_BYTES;
    localparam logic [14:0] ADDR_RESET = 15'h0000;

    // Device address byte layout
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam int DEV_TYPE_MSB = 7;
    localparam int DEV_TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT = 0;

    // Bit counter values: zero, one, and full once a whole byte has passed
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;

    // Which byte of a command is being received
    localparam logic [1:0] BIDX_DEV = 2'h0;
    localparam logic [1:0] BIDX_ADDR_HI = 2'h1;
    localparam logic [1:0] BIDX_ADDR_LO = 2'h2;
    localparam logic [1:0] BIDX_DATA = 2'h3;

    // Self-timed programming, longest time rounds down
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_TIME_MS = 5;
    localparam int PROG_CYCLES_INT = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 17;
    localparam logic [16:0] PROG_CYCLES = 17'(PROG_CYCLES_INT);
    localparam logic [16:0] PROG_CNT_ZERO = 17'h00000;
    localparam logic [16:0] COMMIT_WINDOW = 17'h00040;

    // Link-side synchroniser lanes
    localparam int SYNC_W = 6;
    localparam int LANE_SCL = 0;
    localparam int LANE_SDA = 1;
    localparam int LANE_WP = 2;
    localparam int LANE_SEL_LOW = 3;
    localparam int LANE_SEL_MID = 4;
    localparam int LANE_SEL_HIGH = 5;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX = 6'h02,
        ST_ACK = 6'h04,
        ST_TX = 6'h08,
        ST_MACK = 6'h10,
        ST_PROG = 6'h20
    } tweep_state_t;

endpackage

//--- rtl/tweep_sync.sv
// Two-flop synchroniser for the pins that arrive from outside mclk
`timescale 1ns/10ps
module tweep_sync #(
    parameter int WIDTH = tweep_pkg::SYNC_W
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Lanes
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // Reset to the idle-high bus level so no false scl or sda edge follows
    // release; straps and write protect settle two edges later
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            stage1_reg <= '1;
            stage2_reg <= '1;
        end
        else
        begin
            stage1_reg <= async;
            stage2_reg <= stage1_reg;
        end
    end

    assign synced = stage2_reg;

endmodule // tweep_sync

//--- rtl/tweep_mem.sv
// Byte array of the EEPROM with one write and one registered read port
`timescale 1ns/10ps
module tweep_mem (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Write port
    input wire logic we,
    input wire logic [14:0] wrAddr,
    input wire logic [7:0] wrData,
    // Read port
    input wire logic [14:0] rdAddr,
    output logic [7:0] rdData
);

    // Nonvolatile contents: no reset, so unwritten bytes read as unknown
    logic [7:0] array_reg [0:tweep_pkg::NUM_BYTES-1];
    logic [7:0] rdData_reg;

    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            array_reg[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdData_reg <= 8'h00;
        end
        else
        begin
            rdData_reg <= array_reg[rdAddr];
        end
    end

    assign rdData = rdData_reg;

endmodule // tweep_mem

//--- verification/tweep_slave_asserts.sv
// Port-level concurrent checks for the two-wire EEPROM slave
`timescale 1ns/10ps
module tweep_slave_asserts #(
    parameter logic [16:0] PROG_CYCLES = tweep_pkg::PROG_CYCLES
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link and straps
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic writeProtect,
    // Status
    input wire logic standby
);
    logic [17:0] hiCnt_reg;
    logic prog_reg;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // A long busy stretch with the clock parked high can only be programming
    always_ff @(posedge mclk)
    begin
        if (rst || !scl || standby)
            hiCnt_reg <= 18'h00000;
        else
            hiCnt_reg <= hiCnt_reg + 18'h00001;
        if (rst || standby)
            prog_reg <= 1'b0;
        else if (hiCnt_reg == 18'h00028)
            prog_reg <= 1'b1;
    end
    rst_idle_a: assert property (disable iff (1'b0) rst |=> standby && !sdaOe)
        else $error("not idle after reset");
    idle_quiet_a: assert property (standby |-> !sdaOe)
        else $error("data driven in standby");
    sda_on_low_a: assert property (scl && $past(scl) |-> $stable(sdaOe))
        else $error("data changed while clock high");
    drive_low_a: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
    start_wakes_a: assert property ($fell(standby) |-> scl && !sdaIn)
        else $error("left standby without start");
    busy_bound_a: assert property (hiCnt_reg <= {1'b0, PROG_CYCLES} + 18'h00014)
        else $error("programming overran");
    prog_deaf_a: assert property (prog_reg |-> !sdaOe)
        else $error("answered while programming");
    wp_blocks_a: assert property ($rose(prog_reg) |-> !$past(writeProtect, 32))
        else $error("programmed while protected");
endmodule // tweep_slave_asserts

bind tweep_slave tweep_slave_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_tweep_slave_asserts (
    .mclk(mclk), .rst(rst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .writeProtect(writeProtect), .standby(standby)
);

//--- verification/tweep_master.sv
// Bus controller model that drives the link clock and data
`timescale 1ns/10ps
module tweep_master (
    // Clock
    input wire logic mclk,
    // Link, data pulled low while sdaLow
    input wire logic sdaWire,
    output logic scl,
    output logic sdaLow,
    // One result per byte
    output logic gotValid,
    output logic [7:0] gotData
);
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
        gotValid = 1'b0;
        gotData = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Eight mclk per bit gives the 320 ns link period
    task automatic bitx(input logic b, output logic r);
        sdaLow <= !b;
        w(2);
        scl <= 1'b1;
        w(2);
        @(negedge mclk);
        r = sdaWire;
        w(2);
        scl <= 1'b0;
        w(2);
    endtask
    task automatic sta();
        sdaLow <= 1'b0;
        w(4);
        scl <= 1'b1;
        w(4);
        sdaLow <= 1'b1;
        w(4);
        scl <= 1'b0;
        w(2);
    endtask
    task automatic sto();
        sdaLow <= 1'b1;
        w(4);
        scl <= 1'b1;
        w(4);
        sdaLow <= 1'b0;
        w(4);
    endtask
    task automatic byt(input logic [7:0] d, input logic a, input logic rdMode);
        logic [7:0] q;
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(a, r);
        gotData <= rdMode ? q : {7'h00, r};
        gotValid <= 1'b1;
        w(1);
        gotValid <= 1'b0;
    endtask
endmodule // tweep_master

//--- verification/tb.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/10ps
module tb;
    localparam logic [16:0] PROG = 17'h000C8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] sel = 3'h0;
    logic writeProtect = 1'b0;
    logic scl, sdaLow, sdaOut, sdaOe, standby, gotValid;
    logic [7:0] gotData, want;
    logic [14:0] ctr;
    logic [7:0] mem [int];
    logic [7:0] expq [$];
    int seed = 18593;
    int nFail = 0;
    int checkCount = 0;
    int cycles = 0;
    // Open drain wire with pull-up
    wire logic sdaWire = !(sdaOe && !sdaOut) && !sdaLow;
    tweep_slave #(.PROG_CYCLES(PROG)) i_tweep_slave (
        .mclk(mclk), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .selectBitHigh(sel[2]), .selectBitMid(sel[1]),
        .selectBitLow(sel[0]), .writeProtect(writeProtect), .standby(standby)
    );
    tweep_master i_tweep_master (
        .mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow),
        .gotValid(gotValid), .gotData(gotData)
    );
    always #20 mclk = ~mclk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Results come back in request order, so the oldest note is the one due
    always @(posedge mclk)
    begin
        cycles++;
        if (gotValid)
        begin
            want = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
            checkCount++;
            if (gotData !== want)
            begin
                nFail++;
                $display("unexpected at %0t: got %h want %h", $time, gotData, want);
            end
        end
        if (cycles == 40000)
        begin
            nFail++;
            summarize();
        end
    end
    task automatic tx(input logic [7:0] d, input logic a);
        expq.push_back({7'h00, a});
        i_tweep_master.byt(d, 1'b1, 1'b0);
    endtask
    task automatic cmd(input logic [14:0] a);
        i_tweep_master.sta();
        tx({4'hA, sel, 1'b0}, 1'b0);
        tx({1'($random(seed)), a[14:8]}, 1'b0);
        tx(a[7:0], 1'b0);
        ctr = a;
    endtask
    task automatic pw(input logic [14:0] a, input int n);
        logic [7:0] d;
        cmd(a);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            tx(d, 1'b0);
            if (!writeProtect)
                mem[{a[14:6], 6'(a[5:0] + i)}] = d;
        end
        ctr = {a[14:6], 6'(a[5:0] + n)};
        i_tweep_master.sto();
    endtask
    task automatic cur(input int n);
        i_tweep_master.sta();
        tx({4'hA, sel, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            expq.push_back(mem[ctr]);
            ctr++;
            i_tweep_master.byt(8'hFF, i == n - 1, 1'b1);
        end
        i_tweep_master.sto();
    endtask
    task automatic poll(input logic a);
        i_tweep_master.sta();
        tx({4'hA, sel, 1'b0}, a);
        i_tweep_master.sto();
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        sel <= 3'($random(seed));
        repeat (4) @(posedge mclk);
        pw(15'h013E, 66);
        // Park the clock high long enough for the busy checks to arm
        repeat (50) @(posedge mclk);
        poll(1'b1);
        repeat (PROG) @(posedge mclk);
        poll(1'b0);
        pw(15'h0123, 1);
        repeat (PROG) @(posedge mclk);
        cur(1);
        cmd(15'h0100);
        cur(64);
        $display("test page done");
        pw(15'h7FFF, 1);
        repeat (PROG) @(posedge mclk);
        pw(15'h0000, 1);
        repeat (PROG) @(posedge mclk);
        cmd(15'h7FFF);
        cur(2);
        $display("test wrap done");
        writeProtect <= 1'b1;
        pw(15'h0105, 2);
        poll(1'b0);
        cmd(15'h0104);
        cur(3);
        writeProtect <= 1'b0;
        $display("test protect done");
        for (int k = 1; k < 16; k++)
        begin
            i_tweep_master.sta();
            tx({4'hA ^ 4'(k[3]), sel ^ k[2:0], 1'b0}, 1'b1);
            i_tweep_master.sto();
        end
        $display("test select done");
        cmd(15'h0110);
        tx(8'h5A, 1'b0);
        poll(1'b0);
        cmd(15'h0110);
        cur(1);
        $display("test abort done");
        summarize();
    end
endmodule // tb
